// >>> core/wwdt_core.sv
// Windowed watchdog with a 14-bit down-counter, prescaler and window check.
// Assumes a single clock; the count clock arrives as a one-cycle enable.
`timescale 1ns/1ps
// Function
// - 14-bit counter decrements per prescaled tick.
// - Peripheral instance divides 4 to 8192.
// - Dedicated instance divides 1 to 256.
// - Auto-start counts from reset and after faults.
// - Reset restores counter and configuration registers.
// - Underflow or refresh error stops counting.
// - Restart automatic, or by valid refresh.
// - Window start and end split refresh periods.
// - Refresh outside window is a refresh error.
// - Select bit chooses interrupt or reset request.
// - Status register reads counter without disturbance.
// - Dedicated instance pulses underflow and error events.
// - Dedicated instance freezes counting in low power.
// - Auto-start settings come from boot word zero.
// - Register start settings apply at first refresh.
module wwdt_core #(
  parameter bit KIND = wwdt_pkg::KIND_DEDICATED,
  parameter logic [63:0] TIMEOUT_PERIOD_SELECT_TABLE = 64'h3FFF_1FFF_07FF_03FF,
  parameter logic [7:0] WIN_END_TABLE = 8'hE4,
  parameter logic [7:0] WIN_START_TABLE = 8'hE4
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Count clock enable and low-power mode indication.
  input wire logic count_tick_in,
  input wire logic lowpower_in,
  // Boot option word zero.
  input wire logic [31:0] boot_option_word_zero_in,
  // Register port.
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Requests and events.
  output logic reset_req_out,
  output logic nmi_req_out,
  output logic irq_out,
  output logic underflow_event_out,
  output logic refresh_error_event_out,
  output logic sleep_count_stop_out
);
  localparam int W = wwdt_pkg::CNT_W;

  logic [15:0] indep_wdg_control_r;
  logic [7:0] reset_irq_control_r;
  logic [7:0] lowpower_stop_control_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_enable_r;
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic [8:0] presc_r;
  logic key_armed_r;
  logic boot_taken_r;
  logic auto_mode_r;
  logic [3:0] act_cks_r;
  logic [1:0] act_timeout_period_select_r;
  logic [1:0] act_window_start_select_r;
  logic [1:0] act_window_end_select_r;
  logic act_rstirq_r;
  logic act_lowpower_count_freeze_r;
  wwdt_pkg::wwdt_state_t state_r;
  logic refresh_write;
  logic refresh_valid;
  logic in_window;
  logic tick;
  logic underflow;
  logic refresh_error;
  logic fault;
  logic frozen;
  logic [8:0] div_limit;

  // Timeout count for a timeout select code.
  function automatic logic [W-1:0] timeout_period_select_count(input logic [1:0] sel);
    timeout_period_select_count = TIMEOUT_PERIOD_SELECT_TABLE[{sel, 4'h0} +: W];
  endfunction

  // Window boundary, in quarters of the timeout, for a select code.
  function automatic logic [W-1:0] win_pos(input logic [1:0] code,
    input logic [1:0] sel, input logic [7:0] table_v);
    logic [1:0] q;
    logic [W+1:0] prod;
    q = table_v[{code, 1'b0} +: 2];
    prod = {2'b00, timeout_period_select_count(sel)} * {{W{1'b0}}, q};
    win_pos = prod[W+1:2];
  endfunction

  // Prescaler terminal count minus one, per instance kind.
  function automatic logic [8:0] div_last(input logic [3:0] divide_select);
    logic [8:0] lim;
    lim = 9'h000;
    if (KIND == wwdt_pkg::KIND_PERIPH) begin
      case (divide_select)
        4'h1: lim = 9'h003;
        4'h4: lim = 9'h03F;
        4'h5: lim = 9'h07F;
        4'h6: lim = 9'h1FF;
        4'h7: lim = 9'h1FF;
        4'h8: lim = 9'h1FF;
        default: lim = 9'h003;
      endcase
    end else begin
      case (divide_select)
        4'h0: lim = 9'h000;
        4'h2: lim = 9'h00F;
        4'h3: lim = 9'h01F;
        4'h4: lim = 9'h03F;
        4'h5: lim = 9'h07F;
        4'hF: lim = 9'h0FF;
        default: lim = 9'h000;
      endcase
    end
    div_last = lim;
  endfunction

  // Peripheral ratios 2048 and 8192 extend the 512 stage by 4 and 16.
  logic [4:0] ext_r;
  logic [4:0] ext_last;
  always_comb begin
    ext_last = 5'h00;
    if (KIND == wwdt_pkg::KIND_PERIPH && act_cks_r == 4'h7) begin
      ext_last = 5'h03;
    end else if (KIND == wwdt_pkg::KIND_PERIPH && act_cks_r == 4'h8) begin
      ext_last = 5'h0F;
    end
  end

  assign div_limit = div_last(act_cks_r);
  assign frozen = (KIND == wwdt_pkg::KIND_DEDICATED) && act_lowpower_count_freeze_r &&
    lowpower_in;
  assign sleep_count_stop_out = frozen;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      presc_r <= 9'h000;
      ext_r <= 5'h00;
    end else if (state_r != wwdt_pkg::WWDT_RUN || refresh_valid) begin
      presc_r <= 9'h000;
      ext_r <= 5'h00;
    end else if (count_tick_in && !frozen) begin
      if (presc_r == div_limit) begin
        presc_r <= 9'h000;
        ext_r <= (ext_r == ext_last) ? 5'h00 : ext_r + 5'h01;
      end else begin
        presc_r <= presc_r + 9'h001;
      end
    end
  end

  assign tick = (state_r == wwdt_pkg::WWDT_RUN) && count_tick_in &&
    !frozen &&
    presc_r == div_limit && ext_r == ext_last;

  // Register writes.
  assign refresh_write = wr_in && addr_in == wwdt_pkg::REFRESH_OFS;
  assign refresh_valid = refresh_write && key_armed_r &&
    wdata_in[7:0] == wwdt_pkg::KEY_SECOND;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      key_armed_r <= 1'b0;
    end else if (wr_in) begin
      key_armed_r <= refresh_write &&
        wdata_in[7:0] == wwdt_pkg::KEY_FIRST;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      indep_wdg_control_r <= wwdt_pkg::CONTROL_RST;
      reset_irq_control_r <= wwdt_pkg::RSTIRQ_RST;
      lowpower_stop_control_r <= wwdt_pkg::LPSTOP_RST;
      irq_enable_r <= wwdt_pkg::IRQ_EN_RST;
    end else if (wr_in) begin
      case (addr_in)
        wwdt_pkg::CONTROL_OFS: indep_wdg_control_r <= wdata_in[15:0];
        wwdt_pkg::RSTIRQ_OFS: reset_irq_control_r <= wdata_in[7:0];
        wwdt_pkg::LPSTOP_OFS: lowpower_stop_control_r <= wdata_in[7:0];
        wwdt_pkg::IRQ_EN_OFS: irq_enable_r <= wdata_in[1:0];
        default: irq_enable_r <= irq_enable_r;
      endcase
    end
  end

  // Active settings: boot word at reset release, registers at the first refresh unless auto-start is set.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      boot_taken_r <= 1'b0;
      auto_mode_r <= 1'b0;
      act_cks_r <= 4'h0;
      act_timeout_period_select_r <= 2'h0;
      act_window_start_select_r <= 2'h0;
      act_window_end_select_r <= 2'h0;
      act_rstirq_r <= 1'b0;
      act_lowpower_count_freeze_r <= 1'b0;
    end else if (!boot_taken_r) begin
      boot_taken_r <= 1'b1;
      auto_mode_r <= !boot_option_word_zero_in[wwdt_pkg::BOOT_AUTO_BIT];
      act_cks_r <= boot_option_word_zero_in[wwdt_pkg::BOOT_CKS_LSB +: 4];
      act_timeout_period_select_r <= boot_option_word_zero_in[wwdt_pkg::BOOT_TIMEOUT_PERIOD_SELECT_LSB +: 2];
      act_window_start_select_r <= boot_option_word_zero_in[wwdt_pkg::BOOT_WINDOW_START_SELECT_LSB +: 2];
      act_window_end_select_r <= boot_option_word_zero_in[wwdt_pkg::BOOT_WINDOW_END_SELECT_LSB +: 2];
      act_rstirq_r <= boot_option_word_zero_in[wwdt_pkg::BOOT_RSTIRQ_BIT];
      act_lowpower_count_freeze_r <= boot_option_word_zero_in[wwdt_pkg::BOOT_LOWPOWER_COUNT_FREEZE_BIT];
    end else if (!auto_mode_r && refresh_valid &&
      state_r == wwdt_pkg::WWDT_IDLE) begin
      act_cks_r <= indep_wdg_control_r[wwdt_pkg::CTL_CKS_LSB +: 4];
      act_timeout_period_select_r <= indep_wdg_control_r[wwdt_pkg::CTL_TIMEOUT_PERIOD_SELECT_LSB +: 2];
      act_window_start_select_r <= indep_wdg_control_r[wwdt_pkg::CTL_WINDOW_START_SELECT_LSB +: 2];
      act_window_end_select_r <= indep_wdg_control_r[wwdt_pkg::CTL_WINDOW_END_SELECT_LSB +: 2];
      act_rstirq_r <= reset_irq_control_r[wwdt_pkg::RSTIRQ_BIT];
      act_lowpower_count_freeze_r <= lowpower_stop_control_r[wwdt_pkg::LOWPOWER_COUNT_FREEZE_BIT];
    end
  end

  // Window: permitted while end < count <= start.
  assign in_window = count_r <= win_pos(act_window_start_select_r, act_timeout_period_select_r,
    WIN_START_TABLE) && count_r > win_pos(act_window_end_select_r, act_timeout_period_select_r,
    WIN_END_TABLE);
  assign refresh_error = refresh_valid && state_r == wwdt_pkg::WWDT_RUN &&
    !in_window;
  assign underflow = tick && count_r == '0;
  assign fault = underflow || refresh_error;

  always_comb begin
    count_nxt = count_r;
    if (state_r == wwdt_pkg::WWDT_RUN && refresh_valid &&
      !refresh_error) begin
      count_nxt = timeout_period_select_count(act_timeout_period_select_r);
    end else if (tick && !underflow) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= wwdt_pkg::WWDT_IDLE;
      count_r <= '0;
    end else begin
      case (state_r)
        wwdt_pkg::WWDT_IDLE: begin
          if (boot_taken_r && auto_mode_r) begin
            state_r <= wwdt_pkg::WWDT_RUN;
            count_r <= timeout_period_select_count(act_timeout_period_select_r);
          end else if (boot_taken_r && refresh_valid) begin
            state_r <= wwdt_pkg::WWDT_RUN;
            count_r <= timeout_period_select_count(
              indep_wdg_control_r[wwdt_pkg::CTL_TIMEOUT_PERIOD_SELECT_LSB +: 2]);
          end
        end
        wwdt_pkg::WWDT_RUN: begin
          if (fault) begin
            state_r <= wwdt_pkg::WWDT_STOP;
          end else begin
            count_r <= count_nxt;
          end
        end
        wwdt_pkg::WWDT_STOP: begin
          if (auto_mode_r) begin
            state_r <= wwdt_pkg::WWDT_RUN;
            count_r <= timeout_period_select_count(act_timeout_period_select_r);
          end else if (refresh_valid) begin
            state_r <= wwdt_pkg::WWDT_RUN;
            count_r <= timeout_period_select_count(act_timeout_period_select_r);
          end
        end
        default: state_r <= wwdt_pkg::WWDT_IDLE;
      endcase
    end
  end

  // Request and event outputs, one-cycle pulses from flip-flops.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reset_req_out <= 1'b0;
      nmi_req_out <= 1'b0;
      underflow_event_out <= 1'b0;
      refresh_error_event_out <= 1'b0;
    end else begin
      reset_req_out <= fault && act_rstirq_r;
      nmi_req_out <= fault && !act_rstirq_r;
      underflow_event_out <= (KIND == wwdt_pkg::KIND_DEDICATED) &&
        underflow;
      refresh_error_event_out <= (KIND == wwdt_pkg::KIND_DEDICATED) &&
        refresh_error;
    end
  end

  // Sticky status: bit 0 underflow, bit 1 refresh error; set beats clear.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status_r <= 2'h0;
    end else begin
      irq_status_r <= (irq_status_r & ~((wr_in &&
        addr_in == wwdt_pkg::IRQ_CLR_OFS) ? wdata_in[1:0] : 2'h0)) |
        {refresh_error, underflow};
    end
  end
  assign irq_out = |(irq_status_r & irq_enable_r);

  // Read data, one cycle after the strobe.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      case (addr_in)
        wwdt_pkg::CONTROL_OFS: rdata_out <= {16'h0000, indep_wdg_control_r};
        wwdt_pkg::RSTIRQ_OFS: rdata_out <= {24'h00_0000, reset_irq_control_r};
        wwdt_pkg::LPSTOP_OFS:
          rdata_out <= {24'h00_0000, lowpower_stop_control_r};
        wwdt_pkg::STATUS_OFS:
          rdata_out <= {18'h0_0000, count_r};
        wwdt_pkg::IRQ_STAT_OFS: rdata_out <= {30'h0000_0000, irq_status_r};
        wwdt_pkg::IRQ_EN_OFS: rdata_out <= {30'h0000_0000, irq_enable_r};
        wwdt_pkg::BOOT_OFS: rdata_out <= boot_option_word_zero_in;
        default: rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  // Checks.
  a_count_decrement: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (state_r == wwdt_pkg::WWDT_RUN && tick &&
    !fault && !refresh_valid) |=> count_r == $past(count_r) - 1'b1)
    else $error("Counter did not decrement on tick.");
  a_fault_stops: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (state_r == wwdt_pkg::WWDT_RUN && fault) |=>
    state_r == wwdt_pkg::WWDT_STOP)
    else $error("Fault did not stop counting.");
  a_reset_select: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (fault && act_rstirq_r) |=>
    reset_req_out && !nmi_req_out)
    else $error("Reset request missing.");
  a_nmi_select: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (fault && !act_rstirq_r) |=>
    nmi_req_out && !reset_req_out)
    else $error("Interrupt request missing.");
  a_window_error: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (refresh_valid &&
    state_r == wwdt_pkg::WWDT_RUN && !in_window) |=>
    state_r == wwdt_pkg::WWDT_STOP)
    else $error("Refresh outside window not flagged.");
  a_window_reload: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (refresh_valid &&
    state_r == wwdt_pkg::WWDT_RUN && in_window) |=>
    state_r == wwdt_pkg::WWDT_RUN && count_r == timeout_period_select_count(act_timeout_period_select_r))
    else $error("Refresh inside window did not reload.");
  sequence s_stopped_auto;
    state_r == wwdt_pkg::WWDT_STOP && auto_mode_r;
  endsequence
  a_auto_restart: assert property (@(posedge clk_in)
    disable iff (!resetn_in) s_stopped_auto |=>
    state_r == wwdt_pkg::WWDT_RUN)
    else $error("Auto restart missing.");
  a_status_read: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (rd_in && addr_in == wwdt_pkg::STATUS_OFS)
    |=> rdata_out[W-1:0] == $past(count_r))
    else $error("Status read wrong.");
  a_freeze_hold: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (frozen && state_r == wwdt_pkg::WWDT_RUN &&
    !refresh_valid) |=> count_r == $past(count_r))
    else $error("Counter moved while frozen.");
  a_underflow_event: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (underflow &&
    KIND == wwdt_pkg::KIND_DEDICATED) |=> underflow_event_out)
    else $error("Underflow event missing.");
  a_bad_key: assert property (@(posedge clk_in)
    disable iff (!resetn_in) (refresh_write && !key_armed_r &&
    state_r == wwdt_pkg::WWDT_IDLE && !auto_mode_r) |=>
    state_r == wwdt_pkg::WWDT_IDLE)
    else $error("Refresh accepted without first key.");
endmodule

// >>> core/wwdt_pkg.sv
// Package for the windowed watchdog timer: offsets, fields, reset values.
// Assumes a simple strobe register port with 8-bit register offsets.
package wwdt_pkg;
  // Register offsets.
  localparam logic [7:0] REFRESH_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] RSTIRQ_OFS = 8'h08;
  localparam logic [7:0] LPSTOP_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h1C;
  localparam logic [7:0] BOOT_OFS = 8'h20;
  // Control register field positions.
  localparam int CTL_TIMEOUT_PERIOD_SELECT_LSB = 0;
  localparam int CTL_CKS_LSB = 4;
  localparam int CTL_WINDOW_END_SELECT_LSB = 8;
  localparam int CTL_WINDOW_START_SELECT_LSB = 12;
  // Boot option word zero field positions.
  localparam int BOOT_AUTO_BIT = 1;
  localparam int BOOT_TIMEOUT_PERIOD_SELECT_LSB = 2;
  localparam int BOOT_CKS_LSB = 4;
  localparam int BOOT_WINDOW_END_SELECT_LSB = 8;
  localparam int BOOT_WINDOW_START_SELECT_LSB = 10;
  localparam int BOOT_RSTIRQ_BIT = 12;
  localparam int BOOT_LOWPOWER_COUNT_FREEZE_BIT = 14;
  // Reset values.
  localparam logic [15:0] CONTROL_RST = 16'h33F3;
  localparam logic [7:0] RSTIRQ_RST = 8'h80;
  localparam logic [7:0] LPSTOP_RST = 8'h80;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  // Refresh key bytes.
  localparam logic [7:0] KEY_FIRST = 8'h00;
  localparam logic [7:0] KEY_SECOND = 8'hFF;
  // Counter width; reset-select and low-power freeze bit positions.
  localparam int CNT_W = 14;
  localparam int RSTIRQ_BIT = 7;
  localparam int LOWPOWER_COUNT_FREEZE_BIT = 7;
  // Instance kinds.
  localparam bit KIND_PERIPH = 1'b0;
  localparam bit KIND_DEDICATED = 1'b1;
  // Run states of the counter.
  typedef enum logic [1:0] {
    WWDT_IDLE = 2'b00,
    WWDT_RUN = 2'b01,
    WWDT_STOP = 2'b10
  } wwdt_state_t;
endpackage

// >>> tb/wwdt_tb.sv
// Self-checking bench for the windowed watchdog core, dedicated instance.
// Assumes the core's register port and the package offsets and reset values.
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic count_tick_in = 1'b1;
  logic lowpower_in = 1'b0;
  logic [31:0] boot_option_word_zero_in = 32'h0000_0002;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic reset_req_out;
  logic nmi_req_out;
  logic irq_out;
  logic underflow_event_out;
  logic refresh_error_event_out;
  logic sleep_count_stop_out;
  int n_fail = 0;
  int n_checks = 0;
  int n_rst = 0;
  int n_nmi = 0;
  int n_uf = 0;
  int n_re = 0;
  logic [31:0] d;

  wwdt_core u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .count_tick_in(count_tick_in), .lowpower_in(lowpower_in),
    .boot_option_word_zero_in(boot_option_word_zero_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .reset_req_out(reset_req_out),
    .nmi_req_out(nmi_req_out), .irq_out(irq_out),
    .underflow_event_out(underflow_event_out),
    .refresh_error_event_out(refresh_error_event_out),
    .sleep_count_stop_out(sleep_count_stop_out)
  );

  always #2.5 clk_in = ~clk_in;

  // Counts the one-cycle request and event pulses.
  always @(posedge clk_in) begin
    if (reset_req_out === 1'b1) n_rst <= n_rst + 1;
    if (nmi_req_out === 1'b1) n_nmi <= n_nmi + 1;
    if (underflow_event_out === 1'b1) n_uf <= n_uf + 1;
    if (refresh_error_event_out === 1'b1) n_re <= n_re + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [31:0] boot);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    boot_option_word_zero_in <= boot;
    repeat (10) @(posedge clk_in);
    n_rst = 0;
    n_nmi = 0;
    n_uf = 0;
    n_re = 0;
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  task automatic refresh();
    wr(wwdt_pkg::REFRESH_OFS, {24'h00_0000, wwdt_pkg::KEY_FIRST});
    wr(wwdt_pkg::REFRESH_OFS, {24'h00_0000, wwdt_pkg::KEY_SECOND});
  endtask

  // Reads the counter twice and judges whether it moved down or stood.
  task automatic cnt_moves(input bit run);
    logic [31:0] a;
    logic [31:0] b;
    rd(wwdt_pkg::STATUS_OFS, a);
    repeat (40) @(posedge clk_in);
    rd(wwdt_pkg::STATUS_OFS, b);
    if (run) chk({31'h0, b < a}, 32'h1);
    else chk(b, a);
  endtask

  task automatic wait_fault(input int lim);
    int k;
    int base;
    k = 0;
    base = n_rst + n_nmi;
    while (n_rst + n_nmi == base && k < lim) begin
      @(posedge clk_in);
      k++;
    end
    chk({31'h0, k < lim}, 32'h1);
    repeat (3) @(posedge clk_in);
  endtask

  task automatic t_regs();
    do_reset(32'h0000_0002);
    rd(wwdt_pkg::CONTROL_OFS, d);
    chk(d, {16'h0000, wwdt_pkg::CONTROL_RST});
    rd(wwdt_pkg::RSTIRQ_OFS, d);
    chk(d, {24'h00_0000, wwdt_pkg::RSTIRQ_RST});
    rd(wwdt_pkg::LPSTOP_OFS, d);
    chk(d, {24'h00_0000, wwdt_pkg::LPSTOP_RST});
    rd(wwdt_pkg::IRQ_EN_OFS, d);
    chk(d, {30'h0000_0000, wwdt_pkg::IRQ_EN_RST});
    rd(8'hF0, d);
    chk(d, 32'h0000_0000);
    wr(wwdt_pkg::BOOT_OFS, 32'h0000_0000);
    rd(wwdt_pkg::BOOT_OFS, d);
    chk(d, 32'h0000_0002);
    wr(wwdt_pkg::CONTROL_OFS, 32'h0000_1100);
    rd(wwdt_pkg::CONTROL_OFS, d);
    chk(d, 32'h0000_1100);
  endtask

  task automatic t_regstart();
    wr(wwdt_pkg::RSTIRQ_OFS, 32'h0000_0000);
    wr(wwdt_pkg::IRQ_EN_OFS, 32'h0000_0002);
    cnt_moves(1'b0);
    wr(wwdt_pkg::REFRESH_OFS, 32'h0000_0000);
    wr(wwdt_pkg::REFRESH_OFS, 32'h0000_0055);
    wr(wwdt_pkg::REFRESH_OFS, 32'h0000_00FF);
    cnt_moves(1'b0);
    refresh();
    cnt_moves(1'b1);
    @(posedge clk_in);
    lowpower_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk({31'h0, sleep_count_stop_out}, 32'h1);
    cnt_moves(1'b0);
    @(posedge clk_in);
    lowpower_in <= 1'b0;
    refresh();
    wait_fault(50);
    chk(n_nmi, 1);
    chk(n_rst, 0);
    chk(n_re, 1);
    chk(n_uf, 0);
    chk({31'h0, irq_out}, 32'h1);
    rd(wwdt_pkg::IRQ_STAT_OFS, d);
    chk(d, 32'h0000_0002);
    cnt_moves(1'b0);
    wr(wwdt_pkg::IRQ_EN_OFS, 32'h0000_0000);
    @(posedge clk_in);
    #1;
    chk({31'h0, irq_out}, 32'h0);
    wr(wwdt_pkg::IRQ_EN_OFS, 32'h0000_0002);
    wr(wwdt_pkg::IRQ_CLR_OFS, 32'h0000_0002);
    @(posedge clk_in);
    #1;
    chk({31'h0, irq_out}, 32'h0);
    rd(wwdt_pkg::IRQ_STAT_OFS, d);
    chk(d, 32'h0000_0000);
  endtask

  task automatic t_auto();
    do_reset(32'h0000_1C00);
    rd(wwdt_pkg::CONTROL_OFS, d);
    chk(d, {16'h0000, wwdt_pkg::CONTROL_RST});
    cnt_moves(1'b1);
    repeat (300) @(posedge clk_in);
    refresh();
    rd(wwdt_pkg::STATUS_OFS, d);
    chk({31'h0, d[13:0] > 14'd900}, 32'h1);
    chk(n_rst, 0);
    wait_fault(40000);
    chk(n_rst, 1);
    chk(n_nmi, 0);
    chk(n_uf, 1);
    rd(wwdt_pkg::IRQ_STAT_OFS, d);
    chk(d & 32'h0000_0001, 32'h0000_0001);
    cnt_moves(1'b1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    t_regs();
    t_regstart();
    t_auto();
    report_and_stop();
  end
endmodule
